// ==== core/tpl_pkg.sv ====
// constants, state and struct types for the transmit payload-limit and mac-mode block
package tpl_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SRC = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    // control register field positions
    localparam int CTRL_MM_LSB = 0;
    localparam int CTRL_API_BIT = 2;
    localparam int CTRL_ENC_BIT = 3;
    localparam int CTRL_COMPAT_LSB = 8;
    localparam int CTRL_RR_LSB = 16;
    localparam int COMPAT_TXQ_BIT = 0;
    // reset values
    localparam logic [1:0] MM_RST = 2'h0;
    localparam logic API_RST = 1'b1;
    localparam logic ENC_RST = 1'b0;
    localparam logic [7:0] COMPAT_RST = 8'h00;
    localparam logic [7:0] RR_RST = 8'h00;
    localparam logic [15:0] SRC_RST = 16'h0000;
    // payload limit figures
    localparam logic [7:0] LIM_BASE = 8'd116;
    localparam logic [7:0] LIM_LEG_PLAIN = 8'd100;
    localparam logic [7:0] LIM_LEG_ENC = 8'd95;
    localparam logic [7:0] RED_HDR_PLAIN = 8'd2;
    localparam logic [7:0] RED_HDR_ENC = 8'd4;
    localparam logic [7:0] RED_ADDR = 8'd6;
    localparam logic [7:0] RED_ENC = 8'd5;
    // addresses
    localparam logic [15:0] ADDR_BCAST = 16'hffff;
    localparam logic [15:0] SRC_LONG_A = 16'hffff;
    localparam logic [15:0] SRC_LONG_B = 16'hfffe;
    // transmit status frame
    localparam logic [7:0] STAT_FRAME_TYPE = 8'h89;
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_NOACK = 8'h01;
    localparam logic [7:0] ST_CCA = 8'h02;
    localparam logic [7:0] ST_NETACK = 8'h21;
    localparam logic [7:0] ST_TOO_BIG = 8'h74;
    localparam logic [1:0] MAC_RETRIES = 2'd3;

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} tpl_state_e;

    typedef struct packed {
        logic [1:0] macMode;
        logic apiMode;
        logic encrypt;
        logic [7:0] compat;
        logic [7:0] appRetry;
        logic [15:0] srcAddr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        tpl_state_e state;
        logic reqReady;
        logic [7:0] frameId;
        logic [7:0] remain;
        logic [7:0] chunkMax;
        logic destLong;
        logic bcast;
        logic hdr;
        logic ackEn;
        logic enc;
        logic longSrc;
        logic legacy;
        logic api;
        logic [7:0] rr;
        logic [1:0] macTry;
        logic [7:0] appTry;
        logic txValid;
        logic [7:0] txLen;
        logic txAckReq;
        logic txWantResult;
        logic statusValid;
        logic [7:0] statusCode;
        logic [7:0] statusFrameId;
        logic [15:0] rejectCnt;
        logic [15:0] pktCnt;
        logic dupDetect;
    } tpl_state_s;
endpackage

// ==== core/tpl_tx_payload_limit.sv ====
// transmit payload limit, legacy queue mode, mac mode and retry control with apb registers
//
// Our own choices: the address map and the APB slave port.
module tpl_tx_payload_limit
    import tpl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic [7:0] reqFrameId,
    input wire logic [7:0] reqLen,
    input wire logic reqDestLong,
    input wire logic [15:0] reqDestShort,
    output logic statusValid,
    output logic [7:0] statusType,
    output logic [7:0] statusFrameId,
    output logic [7:0] statusCode,
    output logic txValid,
    input wire logic txReady,
    output logic [7:0] txLen,
    output logic txAckReq,
    output logic txAppHeader,
    output logic txLongSrc,
    output logic txLongDest,
    output logic txBroadcast,
    output logic txEncrypt,
    output logic txWantResult,
    input wire logic resultValid,
    input wire logic resultAcked,
    input wire logic resultCcaFail,
    output logic dupDetectEn
);

    tpl_state_s q;
    tpl_state_s n;

    function automatic logic [7:0] calcLimit(
        input logic legacy,
        input logic enc,
        input logic hdr,
        input logic longSrc,
        input logic longDst
    );
        logic [7:0] lim;
        lim = LIM_BASE;
        if (hdr) begin
            lim = lim - (enc ? RED_HDR_ENC : RED_HDR_PLAIN);
        end
        if (longSrc || enc) begin
            lim = lim - RED_ADDR;
        end
        if (longDst) begin
            lim = lim - RED_ADDR;
        end
        if (enc) begin
            lim = lim - RED_ENC;
        end
        if (legacy) begin
            lim = enc ? LIM_LEG_ENC : LIM_LEG_PLAIN;
        end
        return lim;
    endfunction

    always_comb begin
        logic [7:0] lim;
        logic [7:0] curLim;
        logic legacy;
        logic hdr;
        logic ackEn;
        logic longSrc;
        logic bcast;
        logic pktDone;
        logic pktOk;
        logic [7:0] code;
        logic [7:0] waddr;
        lim = 8'h00;
        legacy = q.compat[COMPAT_TXQ_BIT];
        hdr = (q.macMode == 2'h0) || (q.macMode == 2'h3);
        ackEn = (q.macMode == 2'h0) || (q.macMode == 2'h2);
        longSrc = q.encrypt || (q.srcAddr == SRC_LONG_A) || (q.srcAddr == SRC_LONG_B);
        bcast = !reqDestLong && (reqDestShort == ADDR_BCAST);
        curLim = calcLimit(legacy, q.encrypt, hdr, longSrc, 1'b0);
        pktDone = 1'b0;
        pktOk = 1'b0;
        code = ST_OK;
        waddr = 8'(paddr);
        n = q;
        n.statusValid = 1'b0;
        n.pready = 1'b0;

        // apb: setup cycle prepares answer, access cycle completes with pready
        if (psel && !penable) begin
            n.pready = 1'b1;
            n.pslverr = 1'b0;
            n.prdata = 32'h0000_0000;
            unique case (waddr)
                OFS_CTRL: begin
                    n.prdata[CTRL_MM_LSB +: 2] = q.macMode;
                    n.prdata[CTRL_API_BIT] = q.apiMode;
                    n.prdata[CTRL_ENC_BIT] = q.encrypt;
                    n.prdata[CTRL_COMPAT_LSB +: 8] = q.compat;
                    n.prdata[CTRL_RR_LSB +: 8] = q.appRetry;
                end
                OFS_SRC: begin
                    n.prdata[15:0] = q.srcAddr;
                end
                OFS_STATUS: begin
                    n.prdata[7:0] = curLim;
                    n.prdata[8] = (q.state != ST_IDLE);
                    n.prdata[9] = longSrc;
                    n.prdata[10] = hdr;
                    n.prdata[11] = ackEn;
                end
                OFS_COUNT: begin
                    n.prdata = {q.pktCnt, q.rejectCnt};
                end
                default: begin
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && q.pready && pwrite) begin
            unique case (waddr)
                OFS_CTRL: begin
                    n.macMode = pwdata[CTRL_MM_LSB +: 2];
                    n.apiMode = pwdata[CTRL_API_BIT];
                    n.encrypt = pwdata[CTRL_ENC_BIT];
                    n.compat = pwdata[CTRL_COMPAT_LSB +: 8];
                    n.appRetry = pwdata[CTRL_RR_LSB +: 8];
                end
                OFS_SRC: begin
                    n.srcAddr = pwdata[15:0];
                end
                OFS_COUNT: begin
                    n.pktCnt = 16'h0000;
                    n.rejectCnt = 16'h0000;
                end
                default: begin
                end
            endcase
        end
        if (psel && penable && q.pready) begin
            n.pslverr = 1'b0;
        end
        n.dupDetect = (n.macMode == 2'h0) || (n.macMode == 2'h3);

        unique case (q.state)
            ST_IDLE: begin
                if (reqValid && q.reqReady) begin
                    // configuration snapshot taken at acceptance
                    lim = calcLimit(legacy, q.encrypt, hdr, longSrc, reqDestLong);
                    if (q.apiMode && (reqLen > lim)) begin
                        n.rejectCnt = 16'(q.rejectCnt + 16'h0001);
                        if (reqFrameId != 8'h00) begin
                            n.statusValid = 1'b1;
                            n.statusCode = ST_TOO_BIG;
                            n.statusFrameId = reqFrameId;
                        end
                    end else begin
                        n.reqReady = 1'b0;
                        n.frameId = reqFrameId;
                        n.remain = reqLen;
                        n.chunkMax = lim;
                        n.destLong = reqDestLong;
                        n.bcast = bcast;
                        n.hdr = hdr;
                        n.ackEn = ackEn;
                        n.enc = q.encrypt;
                        n.longSrc = longSrc;
                        n.legacy = legacy;
                        n.api = q.apiMode;
                        n.rr = hdr ? q.appRetry : 8'h00;
                        n.macTry = 2'h0;
                        n.appTry = 8'h00;
                        n.txValid = 1'b1;
                        n.txLen = (reqLen > lim) ? lim : reqLen;
                        n.txAckReq = ackEn && !bcast;
                        // non-queued mode: broadcasts complete at hand-off
                        n.txWantResult = legacy || !bcast;
                        n.state = ST_SEND;
                    end
                end
            end
            ST_SEND: begin
                if (txReady) begin
                    n.txValid = 1'b0;
                    n.pktCnt = 16'(q.pktCnt + 16'h0001);
                    if (q.txWantResult) begin
                        n.state = ST_WAIT;
                    end else begin
                        pktDone = 1'b1;
                        pktOk = 1'b1;
                    end
                end
            end
            ST_WAIT: begin
                if (resultValid) begin
                    if (!resultCcaFail && (resultAcked || !q.txAckReq)) begin
                        pktDone = 1'b1;
                        pktOk = 1'b1;
                    end else if (q.macTry < MAC_RETRIES) begin
                        n.macTry = 2'(q.macTry + 2'h1);
                        n.txValid = 1'b1;
                        n.state = ST_SEND;
                    end else if (q.hdr && (q.appTry < q.rr)) begin
                        n.appTry = 8'(q.appTry + 8'h01);
                        n.macTry = 2'h0;
                        n.txValid = 1'b1;
                        n.state = ST_SEND;
                    end else begin
                        pktDone = 1'b1;
                        if (resultCcaFail) begin
                            code = ST_CCA;
                        end else if (q.hdr && (q.rr != 8'h00)) begin
                            code = ST_NETACK;
                        end else begin
                            code = ST_NOACK;
                        end
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
                n.reqReady = 1'b1;
                n.txValid = 1'b0;
            end
        endcase

        if (pktDone) begin
            if (pktOk && !q.api && (q.remain > q.txLen)) begin
                // next slice of transparent data
                n.remain = 8'(q.remain - q.txLen);
                n.txLen = ((8'(q.remain - q.txLen)) > q.chunkMax) ?
                          q.chunkMax : 8'(q.remain - q.txLen);
                n.macTry = 2'h0;
                n.appTry = 8'h00;
                n.txValid = 1'b1;
                n.state = ST_SEND;
            end else begin
                if (q.api && (q.frameId != 8'h00)) begin
                    n.statusValid = 1'b1;
                    n.statusCode = pktOk ? ST_OK : code;
                    n.statusFrameId = q.frameId;
                end
                n.reqReady = 1'b1;
                n.state = ST_IDLE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            q <= '0;
            q.macMode <= MM_RST;
            q.apiMode <= API_RST;
            q.encrypt <= ENC_RST;
            q.compat <= COMPAT_RST;
            q.appRetry <= RR_RST;
            q.srcAddr <= SRC_RST;
            q.state <= ST_IDLE;
            q.reqReady <= 1'b1;
            q.dupDetect <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign reqReady = q.reqReady;
    assign statusValid = q.statusValid;
    assign statusType = STAT_FRAME_TYPE;
    assign statusFrameId = q.statusFrameId;
    assign statusCode = q.statusCode;
    assign txValid = q.txValid;
    assign txLen = q.txLen;
    assign txAckReq = q.txAckReq;
    assign txAppHeader = q.hdr;
    assign txLongSrc = q.longSrc;
    assign txLongDest = q.destLong;
    assign txBroadcast = q.bcast;
    assign txEncrypt = q.enc;
    assign txWantResult = q.txWantResult;
    assign dupDetectEn = q.dupDetect;

endmodule

// ==== verification/tpl_tx_payload_limit_checker.sv ====
// port assertions for the payload limit block
module tpl_limit_checker
    import tpl_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic [7:0] reqFrameId,
    input wire logic [7:0] reqLen,
    input wire logic reqDestLong,
    input wire logic [15:0] reqDestShort,
    input wire logic statusValid,
    input wire logic [7:0] statusType,
    input wire logic [7:0] statusFrameId,
    input wire logic [7:0] statusCode,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic [7:0] txLen,
    input wire logic txAckReq,
    input wire logic txAppHeader,
    input wire logic txLongSrc,
    input wire logic txBroadcast,
    input wire logic txEncrypt,
    input wire logic dupDetectEn
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    a_status_type: assert property (statusValid |-> statusType == 8'h89)
        else $error("status type wrong");
    a_too_big: assert property (reqValid && reqReady && reqLen > 8'h74
        && reqFrameId != 8'h0 |=> (statusValid && statusCode == 8'h74) || txValid)
        else $error("oversize request not refused");
    a_status_id: assert property (statusValid |-> statusFrameId != 8'h0)
        else $error("status for zero frame id");
    a_bcast_noack: assert property (txValid && txBroadcast |-> !txAckReq)
        else $error("broadcast asks for ack");
    a_bcast_detect: assert property (reqValid && reqReady ##1 txValid
        |-> txBroadcast == (!$past(reqDestLong) && $past(reqDestShort) == 16'hffff))
        else $error("broadcast flag wrong");
    a_hdr_dup: assert property (reqValid && reqReady ##1 txValid
        |-> txAppHeader == $past(dupDetectEn))
        else $error("header and duplicate detection differ");
    a_enc_longsrc: assert property (txValid && txEncrypt |-> txLongSrc)
        else $error("encrypted packet with short source");
    a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txLen)
        && $stable(txAckReq))
        else $error("packet changed before hand-off");
endmodule

// ==== verification/tpl_radio_model.sv ====
// radio side model: accepts packets and answers one result for each that asks for one
module tpl_radio_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic txValid,
    input wire logic txWantResult,
    input wire logic slow,
    input wire logic [1:0] failMode,
    output logic txReady,
    output logic resultValid,
    output logic resultAcked,
    output logic resultCcaFail
);
    timeunit 1ns;
    timeprecision 100ps;
    logic busy_r;
    logic [3:0] dly_r;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            txReady <= 1'b0;
            resultValid <= 1'b0;
            resultAcked <= 1'b0;
            resultCcaFail <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            txReady <= !slow || 1'($urandom);
            resultValid <= 1'b0;
            // result lines carry junk between results
            resultAcked <= ~resultAcked;
            resultCcaFail <= ~resultCcaFail;
            if (txValid && txReady && txWantResult) begin
                busy_r <= 1'b1;
                dly_r <= slow ? 4'h6 : 4'h0;
            end else if (busy_r && dly_r != 4'h0) begin
                dly_r <= dly_r - 4'h1;
            end else if (busy_r) begin
                busy_r <= 1'b0;
                resultValid <= 1'b1;
                resultAcked <= failMode != 2'h1;
                resultCcaFail <= failMode == 2'h2;
            end
        end
    end
endmodule

// ==== verification/tpl_tx_payload_limit_bench.sv ====
// self-checking bench for the payload limit block
module tpl_tx_payload_limit_bench
    import tpl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, re, slow;
    logic [7:0] paddr, reqFrameId, reqLen, statusType, statusFrameId, statusCode, txLen;
    logic [31:0] pwdata, prdata, rv;
    logic reqValid, reqReady, reqDestLong, statusValid, txValid, txReady, txAckReq;
    logic txAppHeader, txLongSrc, txLongDest, txBroadcast, txEncrypt, txWantResult;
    logic resultValid, resultAcked, resultCcaFail, dupDetectEn, leg, enc, ls, ld, hdr, ack;
    logic [15:0] reqDestShort, dst;
    logic [1:0] fm, mm;
    logic [7:0] stCode, hoLen, rr, lm, ln, fid, stFid, stType, lastFid;
    logic hoW;
    logic [5:0] hoF;
    int fails, cmpCount, stCnt, hoCnt, s0, h0, cyc, rej, na;

    tpl_tx_payload_limit u_tpl_tx_payload_limit (.core_clk, .resetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reqValid, .reqReady,
        .reqFrameId, .reqLen, .reqDestLong, .reqDestShort, .statusValid, .statusType,
        .statusFrameId, .statusCode, .txValid, .txReady, .txLen, .txAckReq, .txAppHeader,
        .txLongSrc, .txLongDest, .txBroadcast, .txEncrypt, .txWantResult, .resultValid,
        .resultAcked, .resultCcaFail, .dupDetectEn);
    tpl_radio_model u_tpl_radio_model (.core_clk, .resetn, .txValid, .txWantResult, .slow,
        .failMode(fm), .txReady, .resultValid, .resultAcked, .resultCcaFail);

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // status pulses and hand-offs seen at the ports
    always @(posedge core_clk) begin
        cyc++;
        if (statusValid) begin
            stCnt++;
            stCode = statusCode;
            stFid = statusFrameId;
            stType = statusType;
        end
        if (txValid && txReady) begin
            hoCnt++;
            hoLen = txLen;
            hoF = {txAckReq, txAppHeader, txLongSrc, txLongDest, txBroadcast, txEncrypt};
            hoW = txWantResult;
        end
        if (cyc == 40000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmpCount, fails);
        if (fails == 0 && cmpCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmpCount++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic req(input logic [7:0] f, input logic [7:0] l, input logic dl,
                       input logic [15:0] d);
        s0 = stCnt;
        h0 = hoCnt;
        lastFid = f;
        reqValid <= 1'b1;
        reqFrameId <= f;
        reqLen <= l;
        reqDestLong <= dl;
        reqDestShort <= d;
        do @(posedge core_clk); while (reqReady !== 1'b1);
        reqValid <= 1'b0;
        do @(posedge core_clk); while (reqReady !== 1'b1);
        @(posedge core_clk);
    endtask

    task automatic post(input int ns, input int nh, input logic [7:0] c, input logic [7:0] l,
                        input logic [5:0] f);
        chk("status count", 32'(ns), 32'(stCnt - s0));
        chk("handoffs", 32'(nh), 32'(hoCnt - h0));
        if (ns > 0) chk("status code", {24'h0, c}, {24'h0, stCode});
        if (ns > 0) chk("status type id", {16'h0, 8'h89, lastFid}, {16'h0, stType, stFid});
        if (nh > 0) chk("tx len", {24'h0, l}, {24'h0, hoLen});
        if (nh > 0) chk("tx flags", {26'h0, f}, {26'h0, hoF});
    endtask

    // limit: 116 base, legacy 100 or 95
    function automatic logic [7:0] lim(input logic g, n, h, s, d);
        if (g) return n ? 8'h5f : 8'h64;
        return 8'h74 - (h ? (n ? 8'h4 : 8'h2) : 8'h0) - (s || n ? 8'h6 : 8'h0)
            - (d ? 8'h6 : 8'h0) - (n ? 8'h5 : 8'h0);
    endfunction

    initial begin
        {psel, penable, pwrite, paddr, pwdata, reqValid, reqFrameId, reqLen} = '0;
        {reqDestLong, reqDestShort, fm, slow, resetn} = '0;
        void'($urandom(32'h08a1));
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h4, rv);
        chk("dup detect", 32'h1, {31'h0, dupDetectEn});
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, re});
        for (int i = 0; i < 64; i++) begin
            {leg, enc, mm, ls, ld} = 6'(i);
            rr = 8'($urandom % 3);
            hdr = mm == 2'h0 || mm == 2'h3;
            ack = !mm[0];
            apb(1'b1, OFS_CTRL, {8'h0, rr, 7'h0, leg, 4'h0, enc, 1'b1, mm});
            apb(1'b1, OFS_SRC, ls ? {16'h0, 15'h7fff, 1'($urandom)} : 32'($urandom % 32'h8000));
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("status reg", {20'h0, ack, hdr, ls | enc, 1'b0, lim(leg, enc, hdr, ls, 1'b0)},
                {20'h0, rv[11:0]});
            lm = lim(leg, enc, hdr, ls, ld);
            fid = (i % 5 == 0) ? 8'h0 : 8'($urandom % 255 + 1);
            dst = 16'($urandom % 32'hffff);
            req(fid, lm + 8'h1, ld, dst);
            rej++;
            post(fid != 8'h0, 0, 8'h74, 8'h0, 6'h0);
            ln = lm - 8'($urandom % 4);
            req(fid, ln, ld, dst);
            post(fid != 8'h0, 1, 8'h0, ln, {ack, hdr, ls | enc, ld, 1'b0, enc});
        end
        apb(1'b0, OFS_COUNT, 32'h0);
        chk("rejects", 32'(rej), {16'h0, rv[15:0]});
        for (int j = 0; j < 12; j++) begin
            mm = 2'($urandom);
            rr = 8'($urandom % 3);
            fm <= 2'($urandom % 2 + 1);
            slow <= 1'($urandom);
            hdr = mm == 2'h0 || mm == 2'h3;
            ack = !mm[0];
            apb(1'b1, OFS_CTRL, {8'h0, rr, 8'h0, 4'h0, 2'b01, mm});
            chk("dup detect", {31'h0, hdr}, {31'h0, dupDetectEn});
            na = (hdr && rr != 8'h0) ? 4 * (rr + 1) : 4;
            if (fm == 2'h1 && !ack) na = 1;
            req(8'h7, 8'h32, 1'b0, 16'h1234);
            post(1, na, fm == 2'h2 ? 8'h02 : (na > 4 ? 8'h21 : (na == 1 ? 8'h0 : 8'h01)),
                8'h32, {ack, hdr, 4'b1000});
        end
        fm <= 2'h0;
        slow <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, OFS_CTRL, {23'h0, k[0], 8'h4});
            req(8'h3, 8'h28, 1'b0, 16'hffff);
            post(1, 1, 8'h0, 8'h28, 6'b011010);
            chk("want result", {31'h0, k[0]}, {31'h0, hoW});
        end
        apb(1'b1, OFS_CTRL, 32'h1);
        apb(1'b1, OFS_SRC, 32'h0);
        for (int k = 0; k < 2; k++) begin
            ln = k ? 8'he8 : 8'hfa;
            na = (ln + 115) / 116;
            req(8'h9, ln, 1'b0, 16'h55);
            post(0, na, 8'h0, 8'(ln - (na - 1) * 116), 6'h0);
        end
        end_sim();
    end
endmodule

bind tpl_tx_payload_limit tpl_limit_checker u_tpl_limit_checker (.core_clk, .resetn,
    .reqValid, .reqReady, .reqFrameId, .reqLen, .reqDestLong, .reqDestShort, .statusValid,
    .statusType, .statusFrameId, .statusCode, .txValid, .txReady, .txLen, .txAckReq,
    .txAppHeader, .txLongSrc, .txBroadcast, .txEncrypt, .dupDetectEn);
